// ### design/mcps_pkg.sv
// Package of constants for the multi-chassis power sync block
package mcps_pkg;

    // ------------------------------------------------------------------
    // Register map (APB byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] MCPS_CTRL_ADDR   = 8'h00;
    localparam logic [7:0] MCPS_STATUS_ADDR = 8'h04;

    // CTRL fields
    localparam int MCPS_CTRL_EMB_BIT    = 0;
    localparam int MCPS_CTRL_REMOTE_BIT = 1;
    localparam int MCPS_CTRL_WOL_BIT    = 2;

    // CTRL reset value: no embedded controller, remote power-on off, no WoL
    localparam logic [2:0] MCPS_CTRL_RESET = 3'h0;

    // STATUS fields
    localparam int MCPS_ST_ON_BIT      = 0;
    localparam int MCPS_ST_EMB_BIT     = 1;
    localparam int MCPS_ST_WAKE_BIT    = 2;
    localparam int MCPS_ST_MANUAL_BIT  = 3;
    localparam int MCPS_ST_LOCK_BIT    = 4;
    localparam int MCPS_ST_STATE_LSB   = 8;

    // ------------------------------------------------------------------
    // Group size and timing
    // ------------------------------------------------------------------
    localparam int MCPS_MAX_CHASSIS = 4;
    localparam int MCPS_PEERS       = MCPS_MAX_CHASSIS - 1;

    localparam int MCPS_CLK_MHZ     = 100;
    localparam int MCPS_DEB_US      = 10;
    localparam int MCPS_DEB_CYC     = MCPS_DEB_US * MCPS_CLK_MHZ;
    localparam int MCPS_HOLD_S      = 5;
    localparam longint MCPS_HOLD_CYC = longint'(MCPS_HOLD_S) * 64'd1_000_000 * MCPS_CLK_MHZ;
    localparam int MCPS_SETTLE_US   = 100;
    localparam int MCPS_SETTLE_CYC  = MCPS_SETTLE_US * MCPS_CLK_MHZ;
    localparam int MCPS_WAKE_US     = 50;
    localparam int MCPS_WAKE_CYC    = MCPS_WAKE_US * MCPS_CLK_MHZ;

    typedef enum logic [2:0] {
        MCPS_OFF,
        MCPS_UP_CHASSIS,
        MCPS_UP_EMB,
        MCPS_ON,
        MCPS_DN_EMB,
        MCPS_DN_CHASSIS
    } mcps_state_t;

endpackage : mcps_pkg

// ### design/mcps_debounce.sv
// Synchroniser and debouncer for one input level
`timescale 1ns/1ns
module mcps_debounce #(
    parameter int CYCLES = 1000
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic raw_in,
    output logic      clean_out
);
    import mcps_pkg::*;

    logic        sync1_reg;
    logic        sync2_reg;
    logic [31:0] cnt_reg;

    // First stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else begin
            sync1_reg <= raw_in;
            sync2_reg <= sync1_reg;
        end
    end

    // Level must stay different for CYCLES clocks before it is accepted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg   <= 32'h0000_0000;
            clean_out <= 1'b0;
        end else if (sync2_reg == clean_out) begin
            cnt_reg <= 32'h0000_0000;
        end else if (cnt_reg >= 32'(CYCLES - 1)) begin
            cnt_reg   <= 32'h0000_0000;
            clean_out <= sync2_reg;
        end else begin
            cnt_reg <= cnt_reg + 32'h0000_0001;
        end
    end

endmodule // mcps_debounce

// ### design/mcps_power_sync.sv
// Multi-chassis power sync sequencer with APB control
`timescale 1ns/1ns
module mcps_power_sync #(
    parameter longint HOLD_CYC   = mcps_pkg::MCPS_HOLD_CYC,
    parameter int     DEB_CYC    = mcps_pkg::MCPS_DEB_CYC,
    parameter int     SETTLE_CYC = mcps_pkg::MCPS_SETTLE_CYC,
    parameter int     WAKE_CYC   = mcps_pkg::MCPS_WAKE_CYC
) (
    input  wire logic                            pclk,
    input  wire logic                            presetn,
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [7:0]                      paddr,
    input  wire logic [31:0]                     pwdata,
    output logic                                 pready,
    output logic                                 pslverr,
    output logic [31:0]                          prdata,
    input  wire logic                            button_n,
    input  wire logic [mcps_pkg::MCPS_PEERS-1:0] sync_req_in,
    output logic                                 sync_req_out,
    input  wire logic [mcps_pkg::MCPS_PEERS-1:0] peer_on,
    input  wire logic                            host_on,
    input  wire logic                            wol_event,
    input  wire logic                            manual_override_position,
    input  wire logic                            inhibit_asserted,
    output logic                                 chassis_power_en,
    output logic                                 emb_power_en,
    output logic                                 pcie_wake
);
    import mcps_pkg::*;

    // ------------------------------------------------------------------
    // Input conditioning
    // ------------------------------------------------------------------
    logic                  btn_clean;
    logic [MCPS_PEERS-1:0] req_clean;

    mcps_debounce #(.CYCLES(DEB_CYC)) u_btn (
        .pclk      (pclk),
        .presetn   (presetn),
        .raw_in    (~button_n),
        .clean_out (btn_clean)
    );

    for (genvar g = 0; g < MCPS_PEERS; g++) begin : g_req
        mcps_debounce #(.CYCLES(DEB_CYC)) u_req (
            .pclk      (pclk),
            .presetn   (presetn),
            .raw_in    (sync_req_in[g]),
            .clean_out (req_clean[g])
        );
    end

    logic        btn_d_reg;
    logic [MCPS_PEERS-1:0] req_d_reg;
    logic        host_d_reg;
    logic        wol_d_reg;
    logic [63:0] hold_cnt_reg;
    logic        force_off_reg;

    // Edge history of the conditioned button and requests and of the raw host and wake inputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            btn_d_reg  <= 1'b0;
            req_d_reg  <= '0;
            host_d_reg <= 1'b0;
            wol_d_reg  <= 1'b0;
        end else begin
            btn_d_reg  <= btn_clean;
            req_d_reg  <= req_clean;
            host_d_reg <= host_on;
            wol_d_reg  <= wol_event;
        end
    end

    // Long-press detector; fires once per hold
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_cnt_reg  <= 64'h0000_0000_0000_0000;
            force_off_reg <= 1'b0;
        end else if (!btn_clean) begin
            hold_cnt_reg  <= 64'h0000_0000_0000_0000;
            force_off_reg <= 1'b0;
        end else if (hold_cnt_reg == 64'(HOLD_CYC - 1)) begin
            hold_cnt_reg  <= hold_cnt_reg + 64'h0000_0000_0000_0001;
            force_off_reg <= 1'b1;
        end else begin
            force_off_reg <= 1'b0;
            if (hold_cnt_reg < 64'(HOLD_CYC))
                hold_cnt_reg <= hold_cnt_reg + 64'h0000_0000_0000_0001;
        end
    end

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    logic [2:0] ctrl_reg;
    logic       apb_wr;
    logic       emb_present;
    logic       remote_en;
    logic       wol_en;

    // Write lands only at the edge where the master samples pready high
    assign apb_wr      = psel && penable && pwrite && pready;
    assign emb_present = ctrl_reg[MCPS_CTRL_EMB_BIT];
    assign remote_en   = ctrl_reg[MCPS_CTRL_REMOTE_BIT];
    assign wol_en      = ctrl_reg[MCPS_CTRL_WOL_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ctrl_reg <= MCPS_CTRL_RESET;
        else if (apb_wr && paddr == MCPS_CTRL_ADDR)
            ctrl_reg <= pwdata[2:0];
    end

    // ------------------------------------------------------------------
    // Group request decode
    // ------------------------------------------------------------------
    mcps_state_t state_reg;
    mcps_state_t state_next;
    logic        on_side;
    logic        press;
    logic        peer_press;
    logic        toggle_req;
    logic        on_req;
    logic        host_locked_reg;

    assign on_side    = (state_reg == MCPS_ON) || (state_reg == MCPS_UP_CHASSIS)
                        || (state_reg == MCPS_UP_EMB);
    assign press      = btn_clean && !btn_d_reg;
    // A rising request on the cable is a press seen at a peer chassis
    assign peer_press = |(req_clean & ~req_d_reg);
    assign toggle_req = press || peer_press;
    assign on_req     = toggle_req
                        || (remote_en && host_on && !host_d_reg)
                        || (wol_en && emb_present && wol_event && !wol_d_reg);

    // Lock: remote power-on and a live host make short presses unable to switch off; a long press still forces off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            host_locked_reg <= 1'b0;
        else
            host_locked_reg <= remote_en && host_on;
    end

    logic off_req;
    assign off_req = toggle_req && !host_locked_reg;

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    logic [31:0] seq_cnt_reg;
    logic        settled;
    logic        peers_up;
    logic        peers_down;

    assign settled    = seq_cnt_reg >= 32'(SETTLE_CYC - 1);
    assign peers_up   = &peer_on;
    assign peers_down = ~|peer_on;

    always_comb begin
        state_next = state_reg;
        if (force_off_reg) begin
            state_next = MCPS_OFF;
        end else begin
            unique case (state_reg)
                MCPS_OFF:        if (on_req) state_next = MCPS_UP_CHASSIS;
                MCPS_UP_CHASSIS: if (settled && peers_up)
                                     state_next = emb_present ? MCPS_UP_EMB : MCPS_ON;
                MCPS_UP_EMB:     if (settled) state_next = MCPS_ON;
                MCPS_ON:         if (off_req)
                                     state_next = emb_present ? MCPS_DN_EMB : MCPS_DN_CHASSIS;
                MCPS_DN_EMB:     if (settled) state_next = MCPS_DN_CHASSIS;
                MCPS_DN_CHASSIS: if (settled) state_next = MCPS_OFF;
                default:         state_next = MCPS_OFF;
            endcase
        end
    end

    // Manual mode freezes the sequencer in its current place
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            state_reg <= MCPS_OFF;
        else if (!manual_override_position)
            state_reg <= state_next;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            seq_cnt_reg <= 32'h0000_0000;
        else if (state_next != state_reg || manual_override_position)
            seq_cnt_reg <= 32'h0000_0000;
        else if (!settled)
            seq_cnt_reg <= seq_cnt_reg + 32'h0000_0001;
    end

    // ------------------------------------------------------------------
    // Power outputs
    // ------------------------------------------------------------------
    logic chassis_on_next;
    always_comb begin
        if (manual_override_position)
            chassis_on_next = !inhibit_asserted;
        else
            // A forced stop still lets the embedded controller drop one cycle first
            chassis_on_next = (state_next != MCPS_OFF) || emb_power_en;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chassis_power_en <= 1'b0;
            emb_power_en     <= 1'b0;
        end else begin
            chassis_power_en <= chassis_on_next;
            emb_power_en     <= !manual_override_position && emb_present
                                && (state_next == MCPS_UP_EMB || state_next == MCPS_ON);
        end
    end

    // Drive our own request onto the cable while a local press is seen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            sync_req_out <= 1'b0;
        else
            sync_req_out <= btn_clean && !manual_override_position;
    end

    // Wake pulse stretched over a fixed window after power-up
    logic [31:0] wake_cnt_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_cnt_reg <= 32'h0000_0000;
            pcie_wake    <= 1'b0;
        end else if (chassis_on_next && !chassis_power_en) begin
            wake_cnt_reg <= 32'(WAKE_CYC);
            pcie_wake    <= 1'b1;
        end else if (wake_cnt_reg > 32'h0000_0001) begin
            wake_cnt_reg <= wake_cnt_reg - 32'h0000_0001;
        end else begin
            wake_cnt_reg <= 32'h0000_0000;
            pcie_wake    <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    logic [31:0] status_word;
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[MCPS_ST_ON_BIT]     = chassis_power_en;
        status_word[MCPS_ST_EMB_BIT]    = emb_power_en;
        status_word[MCPS_ST_WAKE_BIT]   = pcie_wake;
        status_word[MCPS_ST_MANUAL_BIT] = manual_override_position;
        status_word[MCPS_ST_LOCK_BIT]   = host_locked_reg;
        status_word[MCPS_ST_STATE_LSB +: 3] = state_reg;
    end

    // One wait state: ready in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (psel && penable && !pready) begin
            pready  <= 1'b1;
            pslverr <= !(paddr == MCPS_CTRL_ADDR || paddr == MCPS_STATUS_ADDR)
                       || (pwrite && paddr == MCPS_STATUS_ADDR);
            if (!pwrite && paddr == MCPS_CTRL_ADDR)
                prdata <= {29'h0000_0000, ctrl_reg};
            else if (!pwrite && paddr == MCPS_STATUS_ADDR)
                prdata <= status_word;
            else
                prdata <= 32'h0000_0000;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    AST_EMB_AFTER_PEERS: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(emb_power_en) |-> peers_up || $past(peers_up))
        else $error("Embedded controller on before peers up");
    AST_EMB_OFF_FIRST: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(chassis_power_en) && !manual_override_position |-> !$past(emb_power_en))
        else $error("Chassis off while embedded controller on");
    AST_LOCK_HOLDS_ON: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == MCPS_ON && host_locked_reg && !force_off_reg
        && !manual_override_position |=> state_reg == MCPS_ON)
        else $error("Group left on-state while host lock active");
    AST_MANUAL_FOLLOW: assert property (@(posedge pclk) disable iff (!presetn)
        manual_override_position && !inhibit_asserted |=> chassis_power_en)
        else $error("Manual mode not following inhibit input");
    AST_WAKE_ON_UP: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(chassis_power_en) |-> pcie_wake)
        else $error("No wake on power up");
    AST_FORCE_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        force_off_reg && !manual_override_position |=> state_reg == MCPS_OFF)
        else $error("Long press did not force off");
    AST_PRESS_ON: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == MCPS_OFF && toggle_req && !force_off_reg
        && !manual_override_position |=> state_reg == MCPS_UP_CHASSIS)
        else $error("Press did not start power up");
    AST_REMOTE_ON: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == MCPS_OFF && remote_en && host_on && !host_d_reg && !force_off_reg
        && !manual_override_position |=> state_reg == MCPS_UP_CHASSIS)
        else $error("Host power-on did not start chassis");
    AST_UNLOCKED_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == MCPS_ON && toggle_req && !host_locked_reg && !emb_present
        && !manual_override_position |=> state_reg == MCPS_DN_CHASSIS)
        else $error("Unlocked press did not power down");
    AST_APB_READY: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready |=> pready)
        else $error("APB ready not given");

    COV_POWER_UP:  cover property (@(posedge pclk) disable iff (!presetn) $rose(chassis_power_en));
    COV_EMB_UP:    cover property (@(posedge pclk) disable iff (!presetn) $rose(emb_power_en));
    COV_LONGPRESS: cover property (@(posedge pclk) disable iff (!presetn) force_off_reg);
    COV_LOCKED:    cover property (@(posedge pclk) disable iff (!presetn)
        state_reg == MCPS_ON && host_locked_reg && toggle_req);

endmodule // mcps_power_sync

// ### tb/mcps_peer_model.sv
// Behavioural model of the three peer chassis on the sync cable
`timescale 1ns/1ns
module mcps_peer_model #(
    parameter int FAST = 3,
    parameter int SLOW = 40
) (
    input  wire logic                            pclk,
    input  wire logic                            presetn,
    input  wire logic                            chassis_power_en,
    input  wire logic                            slow,
    output logic [mcps_pkg::MCPS_PEERS-1:0]      peer_on
);
    import mcps_pkg::*;

    int cnt;

    // ------------------------------------------------------------------
    // Peers follow the group power level, coming up staggered by one cycle each and all dropping together
    // ------------------------------------------------------------------
    // Power loss is immediate; power-up takes time, slow mode stresses the wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt     <= 0;
            peer_on <= '0;
        end else if (!chassis_power_en) begin
            cnt     <= 0;
            peer_on <= '0;
        end else begin
            if (cnt < 1000) begin
                cnt <= cnt + 1;
            end
            for (int i = 0; i < MCPS_PEERS; i++) begin
                peer_on[i] <= (cnt >= (slow ? SLOW : FAST) + i);
            end
        end
    end
endmodule // mcps_peer_model

// ### tb/mcps_power_sync_tb_top.sv
// Self-checking testbench for the multi-chassis power sync block
`timescale 1ns/1ns
module mcps_power_sync_tb_top;
    import mcps_pkg::*;

    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic        pready, pslverr, err, sync_req_out, chassis_power_en, emb_power_en, pcie_wake;
    logic        button_n = 1'b1, host_on = 1'b0, wol_event = 1'b0, slow = 1'b1;
    logic        manual_override_position = 1'b0, inhibit_asserted = 1'b0;
    logic [2:0]  sync_req_in = 3'h0, peer_on;
    int          error_cnt = 0;
    int          checked = 0;

    always #5 pclk = ~pclk;

    mcps_power_sync #(.HOLD_CYC(200), .DEB_CYC(4), .SETTLE_CYC(8), .WAKE_CYC(8))
    mcps_power_sync_inst (
        .pclk                    (pclk),
        .presetn                 (presetn),
        .psel                    (psel),
        .penable                 (penable),
        .pwrite                  (pwrite),
        .paddr                   (paddr),
        .pwdata                  (pwdata),
        .pready                  (pready),
        .pslverr                 (pslverr),
        .prdata                  (prdata),
        .button_n                (button_n),
        .sync_req_in             (sync_req_in),
        .sync_req_out            (sync_req_out),
        .peer_on                 (peer_on),
        .host_on                 (host_on),
        .wol_event               (wol_event),
        .manual_override_position(manual_override_position),
        .inhibit_asserted        (inhibit_asserted),
        .chassis_power_en        (chassis_power_en),
        .emb_power_en            (emb_power_en),
        .pcie_wake               (pcie_wake)
    );

    mcps_peer_model mcps_peer_model_inst (
        .pclk            (pclk),
        .presetn         (presetn),
        .chassis_power_en(chassis_power_en),
        .slow            (slow),
        .peer_on         (peer_on)
    );

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Holds the request until pready is sampled high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) chk(32'h0000_0001, 32'h0000_0000);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic pick(input int w);
        return (w == 0) ? chassis_power_en : (w == 1) ? emb_power_en : sync_req_out;
    endfunction

    task automatic wait_sig(input int w, input logic exp);
        int n;
        n = 0;
        while (pick(w) !== exp && n < 300) begin
            @(posedge pclk);
            n++;
        end
        chk({31'h0000_0000, pick(w)}, {31'h0000_0000, exp});
    endtask

    task automatic wait_st(input logic [2:0] st);
        int n;
        n = 0;
        do begin
            apb(1'b0, MCPS_STATUS_ADDR, 32'h0000_0000);
            n++;
        end while (rd[10:8] !== st && n < 60);
        chk({29'h0000_0000, rd[10:8]}, {29'h0000_0000, st});
    endtask

    task automatic press(input int hold);
        @(posedge pclk);
        button_n <= 1'b0;
        repeat (hold) @(posedge pclk);
        button_n <= 1'b1;
    endtask

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, MCPS_CTRL_ADDR, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        wait_st(3'h0);
        apb(1'b0, 8'h08, 32'h0000_0000);
        chk({31'h0, err}, 32'h0000_0001);
        apb(1'b1, MCPS_STATUS_ADDR, 32'h0000_0007);
        chk({31'h0, err}, 32'h0000_0001);
        apb(1'b1, MCPS_CTRL_ADDR, 32'h0000_0001);
        // Slow peers: the embedded controller must wait for them
        press(6);
        wait_sig(0, 1'b1);
        chk({31'h0, pcie_wake}, 32'h0000_0001);
        chk({31'h0, emb_power_en}, 32'h0000_0000);
        wait_sig(1, 1'b1);
        chk({29'h0, peer_on}, 32'h0000_0007);
        wait_st(3'h3);
        press(6);
        wait_sig(1, 1'b0);
        chk({31'h0, chassis_power_en}, 32'h0000_0001);
        wait_sig(0, 1'b0);
        slow <= 1'b0;
        @(posedge pclk);
        sync_req_in <= 3'h2;
        repeat (8) @(posedge pclk);
        sync_req_in <= 3'h0;
        wait_sig(0, 1'b1);
        wait_st(3'h3);
        apb(1'b1, MCPS_CTRL_ADDR, 32'h0000_0003);
        host_on <= 1'b1;
        button_n <= 1'b0;
        wait_sig(2, 1'b1);
        button_n <= 1'b1;
        repeat (40) @(posedge pclk);
        chk({31'h0, chassis_power_en}, 32'h0000_0001);
        press(230);
        wait_sig(0, 1'b0);
        host_on <= 1'b0;
        repeat (40) @(posedge pclk);
        host_on <= 1'b1;
        wait_sig(0, 1'b1);
        wait_st(3'h3);
        // No embedded controller: the press goes straight to chassis power-down
        apb(1'b1, MCPS_CTRL_ADDR, 32'h0000_0000);
        press(6);
        wait_sig(0, 1'b0);
        host_on <= 1'b0;
        apb(1'b1, MCPS_CTRL_ADDR, 32'h0000_0005);
        apb(1'b0, MCPS_CTRL_ADDR, 32'h0000_0000);
        chk(rd, 32'h0000_0005);
        wol_event <= 1'b1;
        repeat (2) @(posedge pclk);
        wol_event <= 1'b0;
        wait_sig(0, 1'b1);
        wait_st(3'h3);
        press(6);
        wait_sig(0, 1'b0);
        manual_override_position <= 1'b1;
        wait_sig(0, 1'b1);
        inhibit_asserted <= 1'b1;
        wait_sig(0, 1'b0);
        press(6);
        repeat (30) @(posedge pclk);
        chk({30'h0, chassis_power_en, emb_power_en}, 32'h0000_0000);
        final_report();
    end

    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        final_report();
    end
endmodule // mcps_power_sync_tb_top
